// ==== rtl/scl_loader.sv ====
`timescale 1ns/1ns
// What this block does
// - a low-to-high config reset after power-up starts loading from flash
// - this block masters the flash, sending commands and addresses
// - serial clock comes from the block's own clock, no outside source
// - first flash transaction is the wake-from-power-down command
// - read command waits at least 30 us after the wake-up command
// - fast read starts at flash address zero and keeps reading onward
// - serial clock never exceeds the flash's 20 MHz limit
// - byte addressing spans the whole 16 Mbit flash
// - loading starts by itself after power-up with no host action
// - flash port: clock, data out, chip select, write protect, hold
module scl_loader #(
    parameter int IMAGE_BYTES = scl_pkg::FLASH_BYTES,
    parameter int HALF        = scl_pkg::SCLK_HALF
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         configResetN,
    input  wire logic         spiMiso,
    output scl_pkg::scl_spi_s  spiOut,
    output scl_pkg::scl_byte_s cfgStream,
    output logic              loaderBusy,
    output logic              loaderDone
);
    import scl_pkg::*;

    // ========================================================
    // elaboration checks
    if (IMAGE_BYTES < 1 || IMAGE_BYTES > FLASH_BYTES) begin : g_bad_len
        $error("image length must lie within the flash");
    end

    localparam logic [BYTE_W-1:0] LAST_BYTE = BYTE_W'(IMAGE_BYTES - 1);
    localparam logic [WAIT_W-1:0] WAIT_LOAD = WAIT_W'(WAKE_CYCLES);
    localparam logic [WAIT_W-1:0] WAIT_ONE  = WAIT_W'(1);
    localparam logic [5:0]        BIT_ONE   = 6'h01;

    // ========================================================
    // pin synchronisers
    logic [2:0] cfgSync_q;
    logic [1:0] misoSync_q;
    logic       cfgRise;
    logic       cfgHigh;
    logic       misoBit;

    // both pins come from outside; only stage two onward is read
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfgSync_q  <= 3'h0;
            misoSync_q <= 2'h0;
        end else begin
            cfgSync_q  <= {cfgSync_q[1:0], configResetN};
            misoSync_q <= {misoSync_q[0], spiMiso};
        end
    end

    // sync stages clear at reset, so a pin already high reads as a rise
    assign cfgRise = cfgSync_q[1] && !cfgSync_q[2];
    assign cfgHigh = cfgSync_q[1];
    assign misoBit = misoSync_q[1];

    // ========================================================
    // serial clock
    logic run_q;
    logic run_d;
    logic sclkW;
    logic fallTick;

    scl_sclk_gen #(
        .HALF     (HALF)
    ) u_sclk (
        .clk      (clk),
        .reset_n  (reset_n),
        .run      (run_q),
        .sclk     (sclkW),
        .fallTick (fallTick)
    );

    // ========================================================
    // loader sequence
    scl_state_e        state_q,   state_d;
    logic [TX_W-1:0]   tx_q,      tx_d;
    logic [5:0]        bitCnt_q,  bitCnt_d;
    logic [WAIT_W-1:0] waitCnt_q, waitCnt_d;
    logic [7:0]        rx_q,      rx_d;
    logic [BYTE_W-1:0] byteCnt_q, byteCnt_d;
    logic              csN_q,     csN_d;
    logic              mosi_q,    mosi_d;
    logic [7:0]        data_q,    data_d;
    logic              valid_q,   valid_d;
    logic              done_q,    done_d;
    logic              busy_q,    busy_d;
    logic              guardN_q;

    // next state; the flash shifts on sclk falls, so every bit
    // boundary (send and sample alike) sits on fallTick
    always_comb begin
        state_d   = state_q;
        tx_d      = tx_q;
        bitCnt_d  = bitCnt_q;
        waitCnt_d = waitCnt_q;
        rx_d      = rx_q;
        byteCnt_d = byteCnt_q;
        csN_d     = csN_q;
        run_d     = run_q;
        data_d    = data_q;
        valid_d   = 1'b0;
        done_d    = done_q;
        case (state_q)
            S_IDLE: begin
                csN_d = csN_q || (!sclkW && !run_q); // sclk at rest low
                if (cfgRise) begin
                    state_d  = S_WAKE;
                    tx_d     = {OP_WAKE, START_ADDR, DUMMY_BYTE};
                    bitCnt_d = WAKE_BITS;
                    csN_d    = 1'b0;
                    run_d    = 1'b1;
                    done_d   = 1'b0;
                end
            end
            S_WAKE: begin
                if (fallTick) begin
                    tx_d     = tx_q << 1;
                    bitCnt_d = bitCnt_q - BIT_ONE;
                    if (bitCnt_q == BIT_ONE) begin
                        state_d   = S_WAIT;
                        waitCnt_d = WAIT_LOAD;
                        csN_d     = 1'b1;
                        run_d     = 1'b0;
                    end
                end
            end
            S_WAIT: begin
                // counted from the select rise, so the gap is a floor
                waitCnt_d = waitCnt_q - WAIT_ONE;
                if (waitCnt_q == WAIT_ONE) begin
                    state_d  = S_READ;
                    tx_d     = {OP_FAST_READ, START_ADDR, DUMMY_BYTE};
                    bitCnt_d = HDR_BITS;
                    csN_d    = 1'b0;
                    run_d    = 1'b1;
                end
            end
            S_READ: begin
                if (fallTick) begin
                    tx_d     = tx_q << 1;
                    bitCnt_d = bitCnt_q - BIT_ONE;
                    if (bitCnt_q == BIT_ONE) begin
                        state_d   = S_STREAM;
                        bitCnt_d  = BYTE_BITS;
                        byteCnt_d = '0;
                    end
                end
            end
            S_STREAM: begin
                if (fallTick) begin
                    rx_d     = {rx_q[6:0], misoBit}; // msb first
                    bitCnt_d = bitCnt_q - BIT_ONE;
                    if (bitCnt_q == BIT_ONE) begin
                        data_d    = rx_d;
                        valid_d   = 1'b1;
                        bitCnt_d  = BYTE_BITS;
                        byteCnt_d = byteCnt_q + BYTE_W'(1);
                        if (byteCnt_q == LAST_BYTE) begin
                            state_d = S_DONE;
                            csN_d   = 1'b1;
                            run_d   = 1'b0;
                            done_d  = 1'b1;
                        end
                    end
                end
            end
            S_DONE: begin
                state_d = S_DONE;
            end
            default: begin
                state_d = S_IDLE;
                csN_d   = 1'b1;
                run_d   = 1'b0;
            end
        endcase
        // pin pulled low again: back to idle; select waits for sclk
        // to come to rest low, so the flash never sees a cut clock
        if (!cfgHigh && state_q != S_IDLE) begin
            state_d = S_IDLE;
            csN_d   = csN_q || (!sclkW && !run_q);
            run_d   = 1'b0;
            done_d  = 1'b0;
        end
        mosi_d = tx_d[TX_W-1];
        busy_d = (state_d != S_IDLE) && (state_d != S_DONE);
    end

    // registers of the sequence
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q   <= S_IDLE;
            tx_q      <= '0;
            bitCnt_q  <= 6'h00;
            waitCnt_q <= '0;
            rx_q      <= 8'h00;
            byteCnt_q <= '0;
            csN_q     <= 1'b1;
            run_q     <= 1'b0;
            mosi_q    <= 1'b0;
            data_q    <= 8'h00;
            valid_q   <= 1'b0;
            done_q    <= 1'b0;
            busy_q    <= 1'b0;
            guardN_q  <= 1'b1;
        end else begin
            state_q   <= state_d;
            tx_q      <= tx_d;
            bitCnt_q  <= bitCnt_d;
            waitCnt_q <= waitCnt_d;
            rx_q      <= rx_d;
            byteCnt_q <= byteCnt_d;
            csN_q     <= csN_d;
            run_q     <= run_d;
            mosi_q    <= mosi_d;
            data_q    <= data_d;
            valid_q   <= valid_d;
            done_q    <= done_d;
            busy_q    <= busy_d;
            guardN_q  <= 1'b1; // protect and hold never driven active here
        end
    end

    // flash port; protect and hold parked inactive
    assign spiOut.sclk  = sclkW;
    assign spiOut.mosi  = mosi_q;
    assign spiOut.csN   = csN_q;
    assign spiOut.wpN   = guardN_q;
    assign spiOut.holdN = guardN_q;
    assign cfgStream    = '{valid: valid_q, data: data_q};
    assign loaderBusy   = busy_q;
    assign loaderDone   = done_q;

    // ========================================================
    // checks
    logic [WAIT_W:0] gapCnt_q;

    // cycles with select high since the wake command ended
    always_ff @(posedge clk) begin
        if (!reset_n || state_q == S_WAKE) begin
            gapCnt_q <= '0;
        end else if (state_q == S_WAIT && gapCnt_q[WAIT_W] == 1'b0) begin
            gapCnt_q <= gapCnt_q + (WAIT_W + 1)'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_start;
        state_q == S_IDLE && cfgRise && cfgHigh;
    endsequence

    sequence s_wake_sent;
        state_q == S_WAKE && fallTick && bitCnt_q == BIT_ONE;
    endsequence

    a_start_on_rise: assert property (s_start |=>
        state_q == S_WAKE && !csN_q)
        else $error("rise of config reset did not start loading");
    a_wake_first: assert property (s_start |=>
        tx_q[TX_W-1 -: 8] == OP_WAKE)
        else $error("first command is not the wake-up opcode");
    a_wake_closes: assert property (s_wake_sent |=>
        csN_q && state_q == S_WAIT)
        else $error("select not released after wake-up command");
    a_wait_floor: assert property ($rose(state_q == S_READ) |->
        gapCnt_q >= (WAIT_W + 1)'(WAKE_CYCLES))
        else $error("read issued before the wake-up delay");
    a_read_header: assert property ($rose(state_q == S_READ) |->
        tx_q == {OP_FAST_READ, START_ADDR, DUMMY_BYTE} && !csN_q)
        else $error("fast read header wrong");
    a_clock_selected: assert property (sclkW |-> !csN_q)
        else $error("serial clock runs with select high");
    a_byte_spacing: assert property (valid_q |=> !valid_q [*8])
        else $error("bytes delivered faster than the serial rate");
    a_done_count: assert property ($rose(done_q) |->
        $past(byteCnt_q) == LAST_BYTE)
        else $error("load ended at the wrong byte count");
    a_guard_high: assert property (spiOut.wpN && spiOut.holdN)
        else $error("write protect or hold driven active");

endmodule // scl_loader

// ==== rtl/scl_sclk_gen.sv ====
`timescale 1ns/1ns
// ============================================================
// serial clock generator: divides the system clock
module scl_sclk_gen #(
    parameter int HALF = scl_pkg::SCLK_HALF
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic run,
    output logic      sclk,
    output logic      fallTick
);
    import scl_pkg::*;

    localparam int CNT_W = (HALF > 2) ? $clog2(HALF) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF - 1);

    // ========================================================
    // elaboration checks
    if (HALF < 2) begin : g_bad_half
        $error("sclk half period must be at least two cycles");
    end
    if (CLK_MHZ > FLASH_MAX_MHZ * 2 * HALF) begin : g_too_fast
        $error("sclk would exceed the flash clock limit");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             sclk_q;
    logic             sclk_d;

    // next phase; clock idles low so the flash sees mode 0;
    // a high phase always runs full length, so a stop never glitches
    always_comb begin
        cnt_d  = cnt_q;
        sclk_d = sclk_q;
        if (!run && !sclk_q) begin
            cnt_d  = '0;
            sclk_d = 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_d  = '0;
            sclk_d = ~sclk_q;
        end else begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    // clock from the block's own clock, no outside source
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q  <= '0;
            sclk_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            sclk_q <= sclk_d;
        end
    end

    assign sclk     = sclk_q;
    assign fallTick = run && sclk_q && (cnt_q == LAST); // bit ends here

    // ========================================================
    // checks
    a_sclk_high_len: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(sclk_q) |-> sclk_q[*4])
        else $error("sclk high phase shorter than the half period");

endmodule // scl_sclk_gen

// ==== shared/scl_pkg.sv ====
// ============================================================
// shared constants and types of the active configuration loader
package scl_pkg;

    // ========================================================
    // clocking and flash limits
    localparam int CLK_MHZ        = 125;   // system clock rate
    localparam int FLASH_MAX_MHZ  = 20;    // fastest flash serial clock
    localparam int SCLK_HALF      = 4;     // system cycles per half sclk
    localparam int WAKE_WAIT_US   = 30;    // least wait after wake-up
    localparam int WAKE_CYCLES    = WAKE_WAIT_US * CLK_MHZ;
    localparam int WAIT_W         = 12;
    localparam int FLASH_MBITS    = 16;
    localparam int FLASH_BYTES    = FLASH_MBITS * 1024 * 1024 / 8;
    localparam int BYTE_W         = 21;    // byte address width

    // ========================================================
    // flash command frame
    localparam logic [7:0]  OP_WAKE      = 8'hAB;
    localparam logic [7:0]  OP_FAST_READ = 8'h0B;
    localparam logic [23:0] START_ADDR   = 24'h000000;
    localparam logic [7:0]  DUMMY_BYTE   = 8'h00;
    localparam int          TX_W         = 40;
    localparam logic [5:0]  WAKE_BITS    = 6'h08;
    localparam logic [5:0]  HDR_BITS     = 6'h28;
    localparam logic [5:0]  BYTE_BITS    = 6'h08;

    // ========================================================
    // loader states, one-hot
    typedef enum logic [5:0] {
        S_IDLE   = 6'b000001,
        S_WAKE   = 6'b000010,
        S_WAIT   = 6'b000100,
        S_READ   = 6'b001000,
        S_STREAM = 6'b010000,
        S_DONE   = 6'b100000
    } scl_state_e;

    // ========================================================
    // carriers
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic csN;
        logic wpN;
        logic holdN;
    } scl_spi_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } scl_byte_s;

endpackage

// ==== test/scl_flash_model.sv ====
`timescale 1ns/1ns
// ============================================================
// serial flash model, mode 0, answers wake and fast read
// only the loader reaches this flash: no user-mode traffic
module scl_flash_model (
    input  scl_pkg::scl_spi_s spiOut,
    output logic              spiMiso,
    output logic [7:0]        lastOp,
    output logic [7:0]        prevOp,
    output logic [23:0]       addr,
    output int                gapNs,
    output int                minPer
);
    import scl_pkg::*;

    logic [39:0] shiftIn;
    logic [7:0]  dataByte;
    int          bitCnt;
    int          k;
    time         tHigh;
    time         tRise;

    initial begin
        spiMiso = 1'b0;
        lastOp  = 8'h00;
        prevOp  = 8'h00;
        addr    = 24'hFFFFFF;
        shiftIn = 40'h0;
        gapNs   = 0;
        minPer  = 1000000;
        bitCnt  = 0;
        tHigh   = 0;
        tRise   = 0;
    end

    // ========================================================
    // framing: a select fall opens a frame, high time is logged
    always @(negedge spiOut.csN) begin
        bitCnt = 0;
        gapNs  = int'($time - tHigh);
    end
    always @(posedge spiOut.csN) tHigh = $time;

    // commands are taken on sclk rise, msb first
    always @(posedge spiOut.sclk) begin
        if (tRise != 0 && $time - tRise < minPer)
            minPer = int'($time - tRise);
        tRise = $time;
        if (!spiOut.csN) begin
            shiftIn = {shiftIn[38:0], spiOut.mosi};
            bitCnt++;
            if (bitCnt == 8) begin
                prevOp = lastOp;
                lastOp = shiftIn[7:0];
            end
            if (bitCnt == 32)
                addr = shiftIn[23:0];
        end
    end

    // data out on sclk fall after opcode, address and dummy byte;
    // otherwise the line flips so a stale value never looks valid
    always @(negedge spiOut.sclk or posedge spiOut.csN) begin
        k = bitCnt - 40;
        dataByte = 8'h3C + 8'(k / 8) * 8'h11;
        if (!spiOut.csN && lastOp == OP_FAST_READ && k >= 0)
            spiMiso <= dataByte[7 - k % 8];
        else
            spiMiso <= ~spiMiso;
    end
endmodule // scl_flash_model

// ==== test/test_spi_active_config_loader.sv ====
`timescale 1ns/1ns
// ============================================================
// bench of the active configuration loader
module test_spi_active_config_loader;
    import scl_pkg::*;

    localparam int NB = 4;

    logic       clk = 1'b0; // no false fall at time zero
    logic       reset_n;
    logic       configResetN;
    logic       spiMiso;
    scl_spi_s   spiOut;
    scl_byte_s  cfgStream;
    logic       loaderBusy;
    logic       loaderDone;
    logic [7:0] lastOp;
    logic [7:0] prevOp;
    logic [23:0] addr;
    int         gapNs;
    int         minPer;
    int         errors;
    int         num_checks;
    // expected stream: flash byte n in row n
    logic [7:0] rows [NB] = '{8'h3C, 8'h4D, 8'h5E, 8'h6F};

    scl_loader #(.IMAGE_BYTES(NB), .HALF(SCLK_HALF)) scl_loader_inst (
        .clk(clk), .reset_n(reset_n), .configResetN(configResetN),
        .spiMiso(spiMiso), .spiOut(spiOut), .cfgStream(cfgStream),
        .loaderBusy(loaderBusy), .loaderDone(loaderDone));

    scl_flash_model scl_flash_model_inst (
        .spiOut(spiOut), .spiMiso(spiMiso), .lastOp(lastOp),
        .prevOp(prevOp), .addr(addr), .gapNs(gapNs), .minPer(minPer));

    // ========================================================
    // clock and helpers
    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // bounded wait for one stream pulse, sampled mid-cycle
    task automatic waitByte();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cfgStream.valid !== 1'b1 && n < 6000);
        check("stream valid", 1, cfgStream.valid);
    endtask

    // one row per byte, frame checks on the first byte
    task automatic runLoad(int nb);
        for (int i = 0; i < nb; i++) begin
            waitByte();
            check("stream byte", rows[i], cfgStream.data);
            if (i == 0) begin
                check("first op", OP_WAKE, prevOp);
                check("read op", OP_FAST_READ, lastOp);
                check("read addr", START_ADDR, addr);
                check("wake gap", 1, gapNs >= WAKE_WAIT_US * 1000);
                check("busy select", 2'b10, {loaderBusy, spiOut.csN});
                check("wp hold", 2'b11, {spiOut.wpN, spiOut.holdN});
            end
        end
    endtask

    // ========================================================
    // main sequence
    initial begin
        int n;
        errors = 0;
        num_checks = 0;
        reset_n = 1'b0;
        // the bench is the outside controller of the pin
        configResetN = 1'b0; // held low over reset
        repeat (4) @(negedge clk);
        check("reset outs", 6'h38, {spiOut.csN, spiOut.wpN, spiOut.holdN,
              spiOut.sclk, loaderBusy, loaderDone});
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        check("idle select", 1, spiOut.csN);
        configResetN = 1'b1;
        runLoad(NB);
        check("done busy", 2'b10, {loaderDone, loaderBusy});
        check("released", 1, spiOut.csN);
        check("sclk rate", 1, minPer >= 1000 / FLASH_MAX_MHZ);
        repeat (20) @(negedge clk);
        check("done holds", 1, loaderDone);
        // pin low clears done, a new rise starts over
        configResetN = 1'b0;
        repeat (6) @(negedge clk);
        check("done clear", 0, loaderDone);
        configResetN = 1'b1;
        runLoad(2);
        // abort in mid stream
        configResetN = 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        // select waits for run to drop; sclk is in its low phase here
        end while (spiOut.csN !== 1'b1 && n < 16);
        check("abort state", 4'h8, {spiOut.csN, spiOut.sclk, loaderBusy,
              loaderDone});
        repeat (4) @(negedge clk);
        configResetN = 1'b1; // restart reads from zero again
        runLoad(NB);
        check("done again", 2'b10, {loaderDone, loaderBusy});
        final_report();
    end

    // hang guard, well above three loads
    initial begin
        #400000;
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        final_report();
    end
endmodule // test_spi_active_config_loader
